// file: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
	import urhs_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] prdata;
	logic        connect_change_pin;
	logic        suspend_req;
	logic        usb_suspended;
	logic        usb_resuming;
	logic        irq;
	logic [31:0] lfsr;
	logic        seen;
	logic [32:0] exp_q[$];
	int          num_errors;
	int          n_compared;

	urhs_root_hub_status u_urhs_root_hub_status (
		.pclk               (pclk),
		.presetn            (presetn),
		.psel               (psel),
		.penable            (penable),
		.pwrite             (pwrite),
		.paddr              (paddr),
		.pwdata             (pwdata),
		.pready             (pready),
		.pslverr            (pslverr),
		.prdata             (prdata),
		.connect_change_pin (connect_change_pin),
		.suspend_req        (suspend_req),
		.usb_suspended      (usb_suspended),
		.usb_resuming       (usb_resuming),
		.irq                (irq)
	);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	task automatic end_of_test;
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk_word(input string name, input logic [32:0] e, input logic [32:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", name, e, g);
			num_errors++;
		end
	endtask

	task automatic chk_bit(input string name, input logic e, input logic g);
		n_compared++;
		if (g !== e)
		begin
			$display("wrong value %s expected %b seen %b", name, e, g);
			num_errors++;
		end
	endtask

	// The expected answer is noted before the request goes out.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		exp_q.push_back(e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			chk_bit("pready", 1'b1, pready);
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic suspend_and_connect(input int limit);
		suspend_req <= 1'b1;
		@(posedge pclk);
		suspend_req <= 1'b0;
		repeat (3) @(posedge pclk);
		chk_bit("usb_suspended", 1'b1, usb_suspended);
		apb(1'b0, URHS_HUB_CONTROL_OFFS, 32'h0000_0000, {1'b0, 32'h0000_0101});
		connect_change_pin <= ~connect_change_pin;
		seen = 1'b0;
		for (int i = 0; i < limit && !seen; i++)
		begin
			@(posedge pclk);
			seen = (usb_resuming === 1'b1);
		end
	endtask

	always @(posedge pclk)
		if (presetn === 1'b1 && psel && penable && pready === 1'b1)
		begin
			if (exp_q.size() > 0)
				chk_word("apb answer", exp_q.pop_front(), {pslverr, prdata});
			else
				chk_word("unnoted apb answer", 33'h0_0000_0000, {pslverr, prdata});
		end

	initial
	begin
		{psel, penable, pwrite, connect_change_pin, suspend_req} = '0;
		paddr = '0;
		pwdata = '0;
		presetn = 1'b0;
		num_errors = 0;
		n_compared = 0;
		lfsr = 32'hd114_6b1f;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, URHS_ROOT_HUB_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_0000);
		chk_bit("irq", 1'b0, irq);
		for (int i = 0; i < 8; i++)
		begin
			lfsr = lfsr_next(lfsr);
			apb(1'b1, URHS_ROOT_HUB_STATUS_OFFS, (lfsr | 32'h0000_8000) & 32'h7fff_ffff, 33'h0);
			apb(1'b0, URHS_ROOT_HUB_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_8000);
			apb(1'b1, URHS_ROOT_HUB_STATUS_OFFS, lfsr & 32'h7fff_7fff, 33'h0);
			apb(1'b0, URHS_ROOT_HUB_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_8000);
			apb(1'b1, URHS_ROOT_HUB_STATUS_OFFS, lfsr | 32'h8000_0000, 33'h0);
			apb(1'b0, URHS_ROOT_HUB_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_0000);
			apb(1'b1, URHS_ROOT_HUB_STATUS_OFFS, 32'h0000_8000, 33'h0);
		end
		apb(1'b1, 12'h010, 32'hffff_ffff, {1'b1, 32'h0000_0000});
		apb(1'b0, 12'h010, 32'h0000_0000, {1'b1, 32'h0000_0000});
		apb(1'b0, URHS_ROOT_HUB_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_8000);
		suspend_and_connect(20);
		chk_bit("usb_resuming", 1'b1, seen);
		if (!seen)
			end_of_test();
		repeat (3) @(posedge pclk);
		chk_bit("usb_suspended", 1'b0, usb_suspended);
		apb(1'b0, URHS_IRQ_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_0001);
		chk_bit("irq", 1'b0, irq);
		apb(1'b1, URHS_IRQ_MASK_OFFS, 32'h0000_0003, 33'h0);
		repeat (2) @(posedge pclk);
		chk_bit("irq", 1'b1, irq);
		apb(1'b0, URHS_IRQ_MASK_OFFS, 32'h0000_0000, 33'h0_0000_0003);
		apb(1'b1, URHS_IRQ_STATUS_OFFS, 32'h0000_0001, 33'h0);
		repeat (2) @(posedge pclk);
		chk_bit("irq", 1'b0, irq);
		apb(1'b0, URHS_IRQ_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_0000);
		apb(1'b1, URHS_ROOT_HUB_STATUS_OFFS, 32'h8000_0000, 33'h0);
		suspend_and_connect(12);
		chk_bit("usb_resuming", 1'b0, seen);
		chk_bit("usb_suspended", 1'b1, usb_suspended);
		apb(1'b0, URHS_IRQ_STATUS_OFFS, 32'h0000_0000, 33'h0_0000_0000);
		chk_bit("irq", 1'b0, irq);
		end_of_test();
	end
endmodule

// file: verilog/urhs_edge.sv
`timescale 1ns/10ps
module urhs_edge
	import urhs_pkg::*;
(
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Synchronised level in, one-cycle pulse on any change.
	input  wire logic level_in,
	output logic      change
);

	typedef struct packed {
		logic last;
	} urhs_edge_state_t;

	urhs_edge_state_t state;
	urhs_edge_state_t next_state;

	always_comb
	begin
		next_state.last = level_in;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= '0;
		else
			state <= next_state;
	end

	assign change = level_in ^ state.last;

endmodule

// file: verilog/urhs_pkg.sv
package urhs_pkg;

	// Register byte offsets.
	localparam logic [11:0] URHS_ROOT_HUB_STATUS_OFFS = 12'h000;
	localparam logic [11:0] URHS_IRQ_STATUS_OFFS      = 12'h004;
	localparam logic [11:0] URHS_IRQ_MASK_OFFS        = 12'h008;
	localparam logic [11:0] URHS_HUB_CONTROL_OFFS     = 12'h00C;

	// Field positions of the root hub status register.
	localparam int URHS_LOCAL_POWER_STATE_BIT  = 0;
	localparam int URHS_OVERCURRENT_IND_BIT    = 1;
	localparam int URHS_RWE_BIT                = 15;
	localparam int URHS_LOCAL_POWER_CHANGE_BIT = 16;
	localparam int URHS_OVERCURRENT_CHANGE_BIT = 17;
	localparam int URHS_CLEAR_WAKE_BIT         = 31;

	// Field positions of the interrupt status and mask registers.
	localparam int URHS_IRQ_RESUME_BIT      = 0;
	localparam int URHS_IRQ_OVERCURRENT_BIT = 1;
	localparam int URHS_IRQ_WIDTH           = 2;

	// Field positions of the hub control register.
	localparam int URHS_CTL_SUSPEND_BIT = 0;
	localparam int URHS_CTL_STATE_LSB   = 8;

	// Values after reset.
	localparam logic [31:0] URHS_STATUS_RESET = 32'h0000_0000;
	localparam logic        URHS_RWE_RESET    = 1'b0;
	localparam logic [1:0]  URHS_IRQ_RESET    = 2'b00;

	typedef enum logic [1:0] {
		URHS_OPERATIONAL,
		URHS_SUSPEND,
		URHS_RESUME
	} urhs_usb_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} urhs_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} urhs_apb_rsp_t;

endpackage

// file: verilog/urhs_root_hub_status.sv
// Functional notes
// RL1 - Writing one to bit 31 clears remote wake enable; zero leaves it.
// RL2 - Overcurrent change flag sets on indicator change; write one clears it.
// RL3 - Local power change flag resets to zero and has no effect.
// RL4 - Wake enabled: connect change resumes from suspend, sets resume interrupt status.
// RL5 - Wake disabled: connect change keeps suspend, resume status unchanged.
// RL6 - Writing one to bit 15 sets remote wake enable; zero leaves it.
// RL7 - Overcurrent indicator always reads zero.
// RL8 - Local power status resets to zero and has no effect.
// RL9 - Reserved bits read zero and ignore writes.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
module urhs_root_hub_status
	import urhs_pkg::*;
(
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic [31:0]      prdata,
	// Root hub events and state.
	input  wire logic        connect_change_pin,
	input  wire logic        suspend_req,
	output logic             usb_suspended,
	output logic             usb_resuming,
	// Interrupt.
	output logic             irq
);

	typedef struct packed {
		urhs_apb_rsp_t       rsp;
		logic                rwe;
		logic                overcurrent_change_flag;
		logic [1:0]          irq_status;
		logic [1:0]          irq_mask;
		urhs_usb_state_t     usb_state;
		logic                suspended;
		logic                resuming;
		logic                irq;
	} urhs_state_t;

	urhs_state_t   state;
	urhs_state_t   next_state;
	urhs_apb_req_t req;
	logic          connect_sync;
	logic          connect_event;
	logic          overcurrent_level;
	logic          overcurrent_change;
	logic          access;
	logic          wr;
	// Decode helpers that only the checks below read, and the status word that reads return.
	logic          status_wr;
	logic          status_rd;
	logic          mapped;
	logic [31:0]   hub_status_word;

	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

	// The overcurrent indicator has no source pin, so its level is fixed at zero.
	assign overcurrent_level = 1'b0; // RL7

	urhs_sync u_connect_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (connect_change_pin),
		.sync_out (connect_sync)
	);

	urhs_edge u_connect_edge (
		.pclk     (pclk),
		.presetn  (presetn),
		.level_in (connect_sync),
		.change   (connect_event)
	);

	urhs_edge u_overcurrent_edge (
		.pclk     (pclk),
		.presetn  (presetn),
		.level_in (overcurrent_level),
		.change   (overcurrent_change)
	);

	// Accesses are answered in the second access cycle; pready rises two cycles after setup.
	assign access = req.psel && req.penable && !state.rsp.pready;
	assign wr     = access && req.pwrite;

	assign status_wr = wr && req.paddr == URHS_ROOT_HUB_STATUS_OFFS;
	assign status_rd = access && !req.pwrite && req.paddr == URHS_ROOT_HUB_STATUS_OFFS;
	assign mapped    = req.paddr inside {URHS_ROOT_HUB_STATUS_OFFS, URHS_IRQ_STATUS_OFFS,
		URHS_IRQ_MASK_OFFS, URHS_HUB_CONTROL_OFFS};

	always_comb
	begin
		hub_status_word                              = 32'h0000_0000; // RL9
		hub_status_word[URHS_RWE_BIT]                = state.rwe;
		hub_status_word[URHS_OVERCURRENT_CHANGE_BIT] = state.overcurrent_change_flag;
		hub_status_word[URHS_LOCAL_POWER_CHANGE_BIT] = 1'b0; // RL3
		hub_status_word[URHS_OVERCURRENT_IND_BIT]    = overcurrent_level; // RL7
		hub_status_word[URHS_LOCAL_POWER_STATE_BIT]  = 1'b0; // RL8
	end

	always_comb
	begin
		next_state = state;
		next_state.rsp.pready  = access;
		next_state.rsp.pslverr = 1'b0;
		next_state.rsp.prdata  = 32'h0000_0000;

		if (access && !req.pwrite)
		begin
			case (req.paddr)
				URHS_ROOT_HUB_STATUS_OFFS: next_state.rsp.prdata = hub_status_word;
				URHS_IRQ_STATUS_OFFS:
					next_state.rsp.prdata = {30'h0000_0000, state.irq_status};
				URHS_IRQ_MASK_OFFS:
					next_state.rsp.prdata = {30'h0000_0000, state.irq_mask};
				URHS_HUB_CONTROL_OFFS:
				begin
					next_state.rsp.prdata[URHS_CTL_SUSPEND_BIT] = state.suspended;
					next_state.rsp.prdata[URHS_CTL_STATE_LSB +: 2] = state.usb_state;
				end
				default: next_state.rsp.pslverr = 1'b1;
			endcase
		end

		if (wr)
		begin
			case (req.paddr)
				URHS_ROOT_HUB_STATUS_OFFS:
				begin
					// Clear follows set, so a write with both bits leaves wake disabled.
					if (req.pwdata[URHS_RWE_BIT])
						next_state.rwe = 1'b1; // RL6
					if (req.pwdata[URHS_CLEAR_WAKE_BIT])
						next_state.rwe = 1'b0; // RL1
					if (req.pwdata[URHS_OVERCURRENT_CHANGE_BIT])
						next_state.overcurrent_change_flag = 1'b0; // RL2
				end
				URHS_IRQ_STATUS_OFFS:
					next_state.irq_status = state.irq_status & ~req.pwdata[1:0];
				URHS_IRQ_MASK_OFFS:
					next_state.irq_mask = req.pwdata[1:0];
				URHS_HUB_CONTROL_OFFS: ;
				default: next_state.rsp.pslverr = 1'b1;
			endcase
		end

		// Hardware set wins over a software clear in the same cycle.
		if (overcurrent_change)
		begin
			next_state.overcurrent_change_flag = 1'b1; // RL2
			next_state.irq_status[URHS_IRQ_OVERCURRENT_BIT] = 1'b1;
		end

		case (state.usb_state)
			URHS_OPERATIONAL:
				if (suspend_req)
					next_state.usb_state = URHS_SUSPEND;
			URHS_SUSPEND:
				if (connect_event && state.rwe) // RL5
				begin
					next_state.usb_state = URHS_RESUME; // RL4
					next_state.irq_status[URHS_IRQ_RESUME_BIT] = 1'b1; // RL4
				end
			URHS_RESUME:
				next_state.usb_state = URHS_OPERATIONAL;
			default:
				next_state.usb_state = URHS_OPERATIONAL;
		endcase

		next_state.suspended = (next_state.usb_state == URHS_SUSPEND);
		next_state.resuming  = (next_state.usb_state == URHS_RESUME);
		next_state.irq       = |(next_state.irq_status & next_state.irq_mask);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state            <= '0;
			state.rwe        <= URHS_RWE_RESET;
			state.irq_status <= URHS_IRQ_RESET;
			state.irq_mask   <= URHS_IRQ_RESET;
			state.usb_state  <= URHS_OPERATIONAL;
		end
		else
			state <= next_state;
	end

	assign pready        = state.rsp.pready;
	assign pslverr       = state.rsp.pslverr;
	assign prdata        = state.rsp.prdata;
	assign usb_suspended = state.suspended;
	assign usb_resuming  = state.resuming;
	assign irq           = state.irq;

	sequence s_wake_event;
		state.usb_state == URHS_SUSPEND && connect_event && state.rwe;
	endsequence

	sequence s_resumed;
		usb_resuming && state.irq_status[URHS_IRQ_RESUME_BIT];
	endsequence

	a_wake_resume: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		s_wake_event |=> s_resumed)
		else $error("Wake event did not resume and flag");

	a_no_wake_stay: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		(state.usb_state == URHS_SUSPEND && !state.rwe && !suspend_req)
		|=> (state.usb_state == URHS_SUSPEND)
		&& ($stable(state.irq_status[URHS_IRQ_RESUME_BIT]) || $past(wr)))
		else $error("Suspend left without wake enable");

	a_clear_wake: assert property (@(posedge pclk) disable iff (!presetn) // RL1
		(wr && req.paddr == URHS_ROOT_HUB_STATUS_OFFS && req.pwdata[URHS_CLEAR_WAKE_BIT])
		|=> !state.rwe)
		else $error("Clear wake enable ignored");

	a_set_wake: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		(wr && req.paddr == URHS_ROOT_HUB_STATUS_OFFS && req.pwdata[URHS_RWE_BIT]
		&& !req.pwdata[URHS_CLEAR_WAKE_BIT]) |=> state.rwe)
		else $error("Set wake enable ignored");

	a_wake_hold: assert property (@(posedge pclk) disable iff (!presetn) // RL6
		!(wr && req.paddr == URHS_ROOT_HUB_STATUS_OFFS) |=> $stable(state.rwe))
		else $error("Wake enable changed without a write");

	a_overcurrent_clear: assert property (@(posedge pclk) disable iff (!presetn) // RL2
		(status_wr && req.pwdata[URHS_OVERCURRENT_CHANGE_BIT] && !overcurrent_change)
		|=> !state.overcurrent_change_flag)
		else $error("Overcurrent change flag not cleared");

	a_change_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // RL2
		(!overcurrent_change && !(status_wr && req.pwdata[URHS_OVERCURRENT_CHANGE_BIT]))
		|=> $stable(state.overcurrent_change_flag))
		else $error("Overcurrent change flag moved without cause");

	// The fixed bits are checked on the read data itself, not on the internal word.
	a_fixed_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL7
		status_rd |=> (prdata[URHS_OVERCURRENT_IND_BIT] == 1'b0
		&& prdata[URHS_LOCAL_POWER_STATE_BIT] == 1'b0 // RL8
		&& prdata[URHS_LOCAL_POWER_CHANGE_BIT] == 1'b0)) // RL3
		else $error("Fixed status bit not zero");

	a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn) // RL9
		(pready && $past(req.paddr) == URHS_ROOT_HUB_STATUS_OFFS && !$past(req.pwrite))
		|-> (prdata[30:18] == 13'h0000 && prdata[14:2] == 13'h0000))
		else $error("Reserved bits read nonzero");

	sequence s_suspend_entry;
		state.usb_state == URHS_OPERATIONAL && suspend_req;
	endsequence

	sequence s_back_operational;
		!usb_resuming && state.usb_state == URHS_OPERATIONAL;
	endsequence

	// Suspend and resume sequencing.
	a_suspend_enter: assert property (@(posedge pclk) disable iff (!presetn)
		s_suspend_entry |=> usb_suspended)
		else $error("Suspend request not taken");

	a_resume_brief: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		usb_resuming |=> s_back_operational)
		else $error("Resume state lasted more than one cycle");

	a_resume_cause: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		$rose(usb_resuming) |-> ($past(state.rwe) && $past(connect_event)))
		else $error("Resume without an enabled wake event");

	a_no_wake_idle: assert property (@(posedge pclk) disable iff (!presetn) // RL5
		(state.usb_state == URHS_SUSPEND && !state.rwe && connect_event)
		|=> (usb_suspended && !usb_resuming))
		else $error("Connect change woke with wake disabled");

	a_resume_source: assert property (@(posedge pclk) disable iff (!presetn) // RL4
		$rose(state.irq_status[URHS_IRQ_RESUME_BIT])
		|-> ($past(state.rwe) && $past(connect_event)))
		else $error("Resume status set without a wake event");

	a_control_read: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !req.pwrite && req.paddr == URHS_HUB_CONTROL_OFFS && state.suspended)
		|=> prdata[URHS_CTL_SUSPEND_BIT])
		else $error("Control read lost the suspended bit");

	// Interrupt status and mask writes and reads.
	a_irq_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && req.paddr == URHS_IRQ_STATUS_OFFS && req.pwdata[URHS_IRQ_RESUME_BIT]
		&& !(state.usb_state == URHS_SUSPEND && connect_event && state.rwe))
		|=> !state.irq_status[URHS_IRQ_RESUME_BIT])
		else $error("Resume status not cleared by write");

	a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && req.paddr == URHS_IRQ_MASK_OFFS && req.pwdata[1:0] == 2'b11)
		|=> (state.irq_mask == 2'b11))
		else $error("Mask write not taken");

	a_reserved_irq_read: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !req.pwrite
		&& (req.paddr == URHS_IRQ_STATUS_OFFS || req.paddr == URHS_IRQ_MASK_OFFS))
		|=> (prdata[31:2] == '0))
		else $error("Interrupt register upper bits nonzero");

	// Bus answer timing and decode.
	a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
		access |=> pready)
		else $error("Access not answered in the next cycle");

	a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("Ready stood longer than one cycle");

	a_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("Error response without ready");

	a_write_data_zero: assert property (@(posedge pclk) disable iff (!presetn)
		wr |=> (prdata == 32'h0000_0000))
		else $error("Write answer carried read data");

	a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
		(access && !mapped) |=> (pslverr && prdata == 32'h0000_0000))
		else $error("Unmapped access not refused");

	a_unmapped_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && !mapped) |=> ($stable(state.rwe) && $stable(state.irq_mask)))
		else $error("Unmapped write changed a register");

endmodule

// file: verilog/urhs_sync.sv
`timescale 1ns/10ps
module urhs_sync
	import urhs_pkg::*;
(
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Asynchronous level in, synchronised level out.
	input  wire logic async_in,
	output logic      sync_out
);

	typedef struct packed {
		logic stage1;
		logic stage2;
	} urhs_sync_state_t;

	urhs_sync_state_t state;
	urhs_sync_state_t next_state;

	always_comb
	begin
		next_state.stage1 = async_in;
		next_state.stage2 = state.stage1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= '0;
		else
			state <= next_state;
	end

	assign sync_out = state.stage2;

endmodule
